// File: src/pfs_pad_cell.sv
// one pad output stage: picks gpio, lcd or timer drive and registers it
`timescale 1ns/1ps
`default_nettype none
module pfs_pad_cell
	import pfs_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic ce, // clock enable
	input wire pfs_fn_e fn, // selected function
	input wire logic gpio_out, // gpio output value
	input wire logic gpio_oe_n, // gpio output enable, active low
	input wire logic seg_out, // lcd or special drive value
	input wire logic seg_oe_n, // lcd or special enable, active low
	input wire logic tmr_out, // timer output value
	output logic pad_out_q, // registered pad value
	output logic pad_oe_n_q // registered pad enable, active low
);
	logic out_d;
	logic oe_n_d;

	// a timer output always drives the pad
	assign out_d = (fn == PFS_FN_LCD) ? seg_out : (fn == PFS_FN_TMR) ? tmr_out : gpio_out;
	assign oe_n_d = (fn == PFS_FN_LCD) ? seg_oe_n : (fn == PFS_FN_TMR) ? 1'b0 : gpio_oe_n;

	// reset releases the pad so nothing fights the board before software runs
	always_ff @(posedge clock) begin
		if (rst) begin
			pad_out_q <= 1'b0;
			pad_oe_n_q <= 1'b1;
		end else if (ce) begin
			pad_out_q <= out_d;
			pad_oe_n_q <= oe_n_d;
		end
	end
endmodule : pfs_pad_cell
`default_nettype wire

// File: src/pfs_pkg.sv
// package for the port d / port e pin function select block
package pfs_pkg;
	// register addresses on the plain register port
	localparam logic [1:0] PFS_ADDR_PORT_D = 2'h0;
	localparam logic [1:0] PFS_ADDR_PORT_E_LOW = 2'h1;
	localparam logic [1:0] PFS_ADDR_PORT_E_HIGH = 2'h2;

	// values after reset: every field selects general-purpose i/o
	localparam logic [7:0] PFS_RESET_PORT_D = 8'h00;
	localparam logic [7:0] PFS_RESET_PORT_E_LOW = 8'h00;
	localparam logic [7:0] PFS_RESET_PORT_E_HIGH = 8'h00;

	// implemented bits of each register, the rest read as zero
	localparam logic [7:0] PFS_MASK_PORT_D = 8'hFF;
	localparam logic [7:0] PFS_MASK_PORT_E_LOW = 8'h7F;
	localparam logic [7:0] PFS_MASK_PORT_E_HIGH = 8'h1F;

	// field positions in the port e low register
	localparam int PFS_E3_FIELD_LSB = 5;
	localparam int PFS_E2_BIT = 4;
	localparam int PFS_E1_FIELD_LSB = 2;
	localparam int PFS_E0_FIELD_LSB = 0;

	// field positions in the port e high register
	localparam int PFS_E7_BIT = 4;
	localparam int PFS_E6_BIT = 3;
	localparam int PFS_E5_FIELD_LSB = 1;
	localparam int PFS_E4_BIT = 0;

	// port d bits named on their own; only d2 carries extra routing
	localparam int PFS_D2_BIT = 2;
	localparam int PFS_D5_BIT = 5;

	// two-bit field codes
	localparam logic [1:0] PFS_CODE_IO = 2'h0;
	localparam logic [1:0] PFS_CODE_LCD = 2'h1;

	// pad numbering: 0..7 are port d, 8..15 are port e
	localparam int PFS_PADS = 16;
	localparam int PFS_PORT_E_BASE = 8;

	// what a pad is connected to
	typedef enum logic [2:0] {
		PFS_FN_IO = 3'b001,
		PFS_FN_LCD = 3'b010,
		PFS_FN_TMR = 3'b100
	} pfs_fn_e;

	// drive of a group of pads: value and active-low enable
	typedef struct packed {
		logic [15:0] out;
		logic [15:0] oe_n;
	} pfs_drive_s;

	// register port request
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pfs_req_s;
endpackage : pfs_pkg

// File: src/pfs_port_select.sv
// register file and pad multiplexer for port d and port e functions
//
// Our own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module pfs_port_select
	import pfs_pkg::*;
(
	input wire logic clock, // system clock, 50 MHz
	input wire logic rst, // synchronous reset, active high
	input wire logic ce, // clock enable, low freezes all state
	input wire pfs_req_s req, // register port request
	output logic [7:0] rdata_q, // read data, valid the cycle after a read
	input wire pfs_drive_s gpio, // gpio drive for all sixteen pads
	input wire logic [7:0] d_special_out, // port d special function values
	input wire logic [7:0] d_special_oe_n, // port d special function enables, active low
	input wire logic [7:0] lcd_segment_e, // lcd segments eight to fifteen
	input wire logic timer0_output_a, // timer 0 output
	input wire logic timer1_output_a, // timer 1 output
	input wire logic timer2_output_a, // timer 2 output
	input wire logic [15:0] pad_in, // pad input levels
	output logic [15:0] pad_out_q, // pad output values
	output logic [15:0] pad_oe_n_q, // pad output enables, active low
	output logic timer0_clock_input_q // timer 0 clock from pad d2
);
	logic [7:0] port_d_function_select_q;
	logic [7:0] port_e_function_select_low_q;
	logic [7:0] port_e_function_select_high_q;
	logic [7:0] rdata_d;
	logic timer0_clock_input_d;

	// address decode
	wire sel_d = (req.addr == PFS_ADDR_PORT_D);
	wire sel_e_low = (req.addr == PFS_ADDR_PORT_E_LOW);
	wire sel_e_high = (req.addr == PFS_ADDR_PORT_E_HIGH);
	wire wr_d = req.wr & sel_d;
	wire wr_e_low = req.wr & sel_e_low;
	wire wr_e_high = req.wr & sel_e_high;

	// field extraction from the port e registers and port d bits d5, d2
	wire [1:0] pin_e3_select_field = port_e_function_select_low_q[PFS_E3_FIELD_LSB +: 2];
	wire pin_e2_select = port_e_function_select_low_q[PFS_E2_BIT];
	wire [1:0] pin_e1_select_field = port_e_function_select_low_q[PFS_E1_FIELD_LSB +: 2];
	wire [1:0] pin_e0_select_field = port_e_function_select_low_q[PFS_E0_FIELD_LSB +: 2];
	wire pin_e7_select = port_e_function_select_high_q[PFS_E7_BIT];
	wire pin_e6_select = port_e_function_select_high_q[PFS_E6_BIT];
	wire [1:0] pin_e5_select_field = port_e_function_select_high_q[PFS_E5_FIELD_LSB +: 2];
	wire pin_e4_select = port_e_function_select_high_q[PFS_E4_BIT];
	wire pin_d5_select = port_d_function_select_q[PFS_D5_BIT];
	wire pin_d2_select = port_d_function_select_q[PFS_D2_BIT];

	// unmapped addresses read as zero; unimplemented bits are never stored
	assign rdata_d = !req.rd ? 8'h00 :
		sel_d ? (port_d_function_select_q & PFS_MASK_PORT_D) :
		sel_e_low ? (port_e_function_select_low_q & PFS_MASK_PORT_E_LOW) :
		sel_e_high ? (port_e_function_select_high_q & PFS_MASK_PORT_E_HIGH) :
		8'h00;

	// register writes; a write to an unmapped address is dropped
	always_ff @(posedge clock) begin
		if (rst) begin
			port_d_function_select_q <= PFS_RESET_PORT_D;
			port_e_function_select_low_q <= PFS_RESET_PORT_E_LOW;
			port_e_function_select_high_q <= PFS_RESET_PORT_E_HIGH;
		end else if (ce) begin
			if (wr_d) begin
				port_d_function_select_q <= req.wdata & PFS_MASK_PORT_D;
			end
			if (wr_e_low) begin
				port_e_function_select_low_q <= req.wdata & PFS_MASK_PORT_E_LOW;
			end
			if (wr_e_high) begin
				port_e_function_select_high_q <= req.wdata & PFS_MASK_PORT_E_HIGH;
			end
		end
	end

	// read data stands for exactly one cycle, zero otherwise
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_q <= 8'h00;
		end else if (ce) begin
			rdata_q <= rdata_d;
		end
	end

	// per-pad function and alternate sources
	pfs_fn_e pin_fn [PFS_PADS];
	logic [15:0] seg_out;
	logic [15:0] seg_oe_n;
	logic [15:0] tmr_out;

	// port d: one bit per pad, the special function arrives ready-made from outside
	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_port_d
			assign pin_fn[gi] = port_d_function_select_q[gi] ? PFS_FN_LCD : PFS_FN_IO;
			assign seg_out[gi] = d_special_out[gi];
			assign seg_oe_n[gi] = d_special_oe_n[gi];
			assign tmr_out[gi] = 1'b0;
		end
	endgenerate

	// port e segments always drive their pad when selected
	assign seg_out[15:8] = lcd_segment_e;
	assign seg_oe_n[15:8] = 8'h00;

	// port e pads 0 to 3 from the low register
	assign pin_fn[PFS_PORT_E_BASE + 0] = (pin_e0_select_field == PFS_CODE_LCD) ? PFS_FN_LCD : PFS_FN_IO;
	assign pin_fn[PFS_PORT_E_BASE + 1] = (pin_e1_select_field == PFS_CODE_IO) ? PFS_FN_IO :
		(pin_e1_select_field == PFS_CODE_LCD) ? PFS_FN_LCD : PFS_FN_TMR;
	assign pin_fn[PFS_PORT_E_BASE + 2] = pin_e2_select ? PFS_FN_LCD : PFS_FN_IO;
	assign pin_fn[PFS_PORT_E_BASE + 3] = (pin_e3_select_field == PFS_CODE_IO) ? PFS_FN_IO :
		(pin_e3_select_field == PFS_CODE_LCD) ? PFS_FN_LCD : PFS_FN_TMR;

	// port e pads 4 to 7 from the high register
	assign pin_fn[PFS_PORT_E_BASE + 4] = pin_e4_select ? PFS_FN_LCD : PFS_FN_IO;
	assign pin_fn[PFS_PORT_E_BASE + 5] = (pin_e5_select_field == PFS_CODE_IO) ? PFS_FN_IO :
		(pin_e5_select_field == PFS_CODE_LCD) ? PFS_FN_LCD : PFS_FN_TMR;
	assign pin_fn[PFS_PORT_E_BASE + 6] = pin_e6_select ? PFS_FN_LCD : PFS_FN_IO;
	assign pin_fn[PFS_PORT_E_BASE + 7] = pin_e7_select ? PFS_FN_LCD : PFS_FN_IO;

	// timer outputs reach only the pads that can carry them
	assign tmr_out[PFS_PORT_E_BASE + 0] = 1'b0;
	assign tmr_out[PFS_PORT_E_BASE + 1] = timer0_output_a;
	assign tmr_out[PFS_PORT_E_BASE + 2] = 1'b0;
	assign tmr_out[PFS_PORT_E_BASE + 3] = timer1_output_a;
	assign tmr_out[PFS_PORT_E_BASE + 4] = 1'b0;
	assign tmr_out[PFS_PORT_E_BASE + 5] = timer2_output_a;
	assign tmr_out[PFS_PORT_E_BASE + 6] = 1'b0;
	assign tmr_out[PFS_PORT_E_BASE + 7] = 1'b0;

	// the timer sees its clock only while d2 is given away, so gpio toggling cannot count
	assign timer0_clock_input_d = pin_d2_select & pad_in[PFS_D2_BIT];

	always_ff @(posedge clock) begin
		if (rst) begin
			timer0_clock_input_q <= 1'b0;
		end else if (ce) begin
			timer0_clock_input_q <= timer0_clock_input_d;
		end
	end

	// one registered output stage per pad
	generate
		for (gi = 0; gi < PFS_PADS; gi++) begin : g_pad
			pfs_pad_cell u_cell (
				.clock(clock),
				.rst(rst),
				.ce(ce),
				.fn(pin_fn[gi]),
				.gpio_out(gpio.out[gi]),
				.gpio_oe_n(gpio.oe_n[gi]),
				.seg_out(seg_out[gi]),
				.seg_oe_n(seg_oe_n[gi]),
				.tmr_out(tmr_out[gi]),
				.pad_out_q(pad_out_q[gi]),
				.pad_oe_n_q(pad_oe_n_q[gi])
			);
		end
	endgenerate

	// d5 needs nothing beyond the generic port d path; kept named for readability
	wire unused_d5 = pin_d5_select;
endmodule : pfs_port_select
`default_nettype wire

// File: verif/pfs_checker.sv
// assertion checker for the pin function select block
`timescale 1ns/1ps
`default_nettype none
module pfs_checker
	import pfs_pkg::*;
(
	input wire logic clock, // system clock
	input wire logic rst, // sync reset
	input wire logic ce, // clock enable
	input wire pfs_req_s req, // register request
	input wire logic [7:0] rdata_q, // read data
	input wire pfs_drive_s gpio, // gpio drive
	input wire logic [7:0] d_special_out, // port d special value
	input wire logic [7:0] d_special_oe_n, // port d special enable
	input wire logic [7:0] lcd_segment_e, // lcd segments
	input wire logic timer0_output_a, // timer 0
	input wire logic timer1_output_a, // timer 1
	input wire logic timer2_output_a, // timer 2
	input wire logic [15:0] pad_in, // pad levels
	input wire logic [15:0] pad_out_q, // pad values
	input wire logic [15:0] pad_oe_n_q, // pad enables
	input wire logic timer0_clock_input_q // timer 0 clock
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic [7:0] d_q, lo_q, hi_q;
	// shadow selects, so pad checks need not peek inside
	always_ff @(posedge clock) begin
		if (rst) begin
			d_q <= 8'h00;
			lo_q <= 8'h00;
			hi_q <= 8'h00;
		end else if (ce && req.wr) begin
			if (req.addr == PFS_ADDR_PORT_D) d_q <= req.wdata;
			if (req.addr == PFS_ADDR_PORT_E_LOW) lo_q <= req.wdata & PFS_MASK_PORT_E_LOW;
			if (req.addr == PFS_ADDR_PORT_E_HIGH) hi_q <= req.wdata & PFS_MASK_PORT_E_HIGH;
		end
	end
	// pads d5, e0 to e3, e5 and the d2 timer clock follow their source one enabled cycle later; e low bit 7 reads zero
	a_d5_special: assert property (
		ce && d_q[5] |=> pad_out_q[5] == $past(d_special_out[5])) else $error("d5 special wrong");
	a_d5_gpio: assert property (
		ce && !d_q[5] |=> pad_oe_n_q[5] == $past(gpio.oe_n[5])) else $error("d5 gpio wrong");
	a_d2_clock: assert property (
		ce |=> timer0_clock_input_q == $past(pad_in[2] & d_q[2])) else $error("timer clock wrong");
	a_elow_top: assert property (
		ce && req.rd && req.addr == PFS_ADDR_PORT_E_LOW |=> !rdata_q[7]) else $error("bit7 not zero");
	a_e3_timer: assert property (
		ce && lo_q[6] |=> pad_out_q[11] == $past(timer1_output_a) && !pad_oe_n_q[11]) else $error("e3 wrong");
	a_e2_lcd: assert property (
		ce && lo_q[4] |=> pad_out_q[10] == $past(lcd_segment_e[2]) && !pad_oe_n_q[10]) else $error("e2 wrong");
	a_e1_timer: assert property (
		ce && lo_q[3] |=> pad_out_q[9] == $past(timer0_output_a) && !pad_oe_n_q[9]) else $error("e1 wrong");
	a_e0_gpio: assert property (
		ce && lo_q[1] |=> pad_oe_n_q[8] == $past(gpio.oe_n[8])) else $error("e0 wrong");
	a_e5_timer: assert property (
		ce && hi_q[2] |=> pad_out_q[13] == $past(timer2_output_a) && !pad_oe_n_q[13]) else $error("e5 wrong");
endmodule : pfs_checker
`default_nettype wire

// File: verif/pfs_port_select_tb.sv
// self-checking bench for the pin function select block
`timescale 1ns/1ps
`default_nettype none
module pfs_port_select_tb import pfs_pkg::*;;
	localparam logic [1:0] IO = 2'h1, LCD = 2'h2, TMR = 2'h0; // {out, oe_n}
	logic clock = 0, rst = 1, ce = 1, tck;
	pfs_req_s req = '0;
	pfs_drive_s gpio = {16'h0000, 16'hFFFF};
	logic [7:0] dso = 8'hFF, dsoe = 8'h00, lcd = 8'hFF, rdq;
	logic t0 = 0, t1 = 0, t2 = 0;
	logic [15:0] pin = 16'hFFFF, po, poe;
	int fail_count = 0, num_checks = 0;
	pfs_port_select pfs_port_select_inst (.clock(clock), .rst(rst), .ce(ce), .req(req), .rdata_q(rdq),
		.gpio(gpio), .d_special_out(dso), .d_special_oe_n(dsoe), .lcd_segment_e(lcd),
		.timer0_output_a(t0), .timer1_output_a(t1), .timer2_output_a(t2), .pad_in(pin),
		.pad_out_q(po), .pad_oe_n_q(poe), .timer0_clock_input_q(tck));
	initial forever #10 clock = ~clock;
	// expected pad pair for a field code; others fall to timer or gpio
	function automatic logic [1:0] fn(logic [1:0] c, logic t);
		return c == 2'h0 ? IO : c == 2'h1 ? LCD : t ? TMR : IO;
	endfunction : fn
	task automatic chk(string n, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(logic [1:0] a, logic [7:0] d);
		@(posedge clock);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		req <= '{a, d, 1'b0, 1'b0};
	endtask : wr
	// read data stands only in the cycle after the strobe
	task automatic rd(logic [1:0] a, logic [7:0] e);
		@(posedge clock);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		req <= '{a, 8'h00, 1'b0, 1'b0};
		#1 chk("rdata", 16'(e), 16'(rdq));
	endtask : rd
	task automatic settle;
		repeat (2) @(posedge clock);
		#1;
	endtask : settle
	task automatic t_regs;
		rd(PFS_ADDR_PORT_D, 8'h00);
		rd(PFS_ADDR_PORT_E_LOW, 8'h00);
		rd(PFS_ADDR_PORT_E_HIGH, 8'h00);
		wr(PFS_ADDR_PORT_E_LOW, 8'hFF);
		wr(PFS_ADDR_PORT_E_HIGH, 8'hFF);
		wr(2'h3, 8'hFF);
		rd(PFS_ADDR_PORT_E_LOW, 8'h7F);
		rd(PFS_ADDR_PORT_E_HIGH, 8'h1F);
		rd(2'h3, 8'h00);
		$display("test regs done");
	endtask : t_regs
	task automatic t_elow;
		for (int c = 0; c < 4; c++) begin
			wr(PFS_ADDR_PORT_E_LOW, 8'((c << 5) | ((c & 1) << 4) | (c << 2) | c));
			settle();
			chk("e3", 16'(fn(2'(c), 1)), 16'({po[11], poe[11]}));
			chk("e2", 16'(fn(2'(c & 1), 0)), 16'({po[10], poe[10]}));
			chk("e1", 16'(fn(2'(c), 1)), 16'({po[9], poe[9]}));
			chk("e0", 16'(fn(2'(c), 0)), 16'({po[8], poe[8]}));
		end
		$display("test port e low done");
	endtask : t_elow
	task automatic t_ehigh;
		for (int c = 0; c < 4; c++) begin
			wr(PFS_ADDR_PORT_E_HIGH, 8'(((c & 1) << 4) | ((c & 1) << 3) | (c << 1) | (c & 1)));
			settle();
			chk("e7", 16'(fn(2'(c & 1), 0)), 16'({po[15], poe[15]}));
			chk("e6", 16'(fn(2'(c & 1), 0)), 16'({po[14], poe[14]}));
			chk("e5", 16'(fn(2'(c), 1)), 16'({po[13], poe[13]}));
			chk("e4", 16'(fn(2'(c & 1), 0)), 16'({po[12], poe[12]}));
		end
		$display("test port e high done");
	endtask : t_ehigh
	task automatic t_portd;
		wr(PFS_ADDR_PORT_D, 8'h24);
		settle();
		chk("d out", 16'h0024, 16'(po[7:0]));
		chk("d oe_n", 16'h00DB, 16'(poe[7:0]));
		chk("tck on", 16'h0001, 16'(tck));
		wr(PFS_ADDR_PORT_D, 8'h00);
		settle();
		chk("tck off", 16'h0000, 16'(tck));
		chk("d idle", 16'h00FF, 16'(poe[7:0]));
		$display("test port d done");
	endtask : t_portd
	// timer 1 and the other two must not share a pad, so drive t1 against t0 and t2 and then swap
	task automatic t_tmr;
		wr(PFS_ADDR_PORT_E_LOW, 8'h48);
		wr(PFS_ADDR_PORT_E_HIGH, 8'h04);
		t0 <= 1'b0;
		t1 <= 1'b1;
		t2 <= 1'b0;
		settle();
		chk("e3 tmr hi", 16'h0001, 16'(po[11]));
		chk("e1 tmr lo", 16'h0000, 16'(po[9]));
		chk("e5 tmr lo", 16'h0000, 16'(po[13]));
		@(posedge clock);
		t0 <= 1'b1;
		t1 <= 1'b0;
		t2 <= 1'b1;
		settle();
		chk("e3 tmr lo", 16'h0000, 16'(po[11]));
		chk("e1 tmr hi", 16'h0001, 16'(po[9]));
		chk("e5 tmr hi", 16'h0001, 16'(po[13]));
		$display("test timers done");
	endtask : t_tmr
	// a write while the enable is low must leave the select untouched
	task automatic t_ce;
		@(posedge clock);
		ce <= 1'b0;
		wr(PFS_ADDR_PORT_D, 8'hFF);
		settle();
		chk("ce frozen pads", 16'h00FF, 16'(poe[7:0]));
		@(posedge clock);
		ce <= 1'b1;
		rd(PFS_ADDR_PORT_D, 8'h00);
		$display("test clock enable done");
	endtask : t_ce
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		t_regs();
		t_elow();
		t_ehigh();
		t_portd();
		t_ce();
		t_tmr();
		conclude();
	end
	// watchdog well past the roughly 80 cycles the tests take
	initial begin
		repeat (3000) @(posedge clock);
		fail_count++;
		conclude();
	end
endmodule : pfs_port_select_tb
bind pfs_port_select pfs_checker pfs_checker_inst (.clock(clock), .rst(rst), .ce(ce), .req(req),
	.rdata_q(rdata_q), .gpio(gpio), .d_special_out(d_special_out), .d_special_oe_n(d_special_oe_n),
	.lcd_segment_e(lcd_segment_e), .timer0_output_a(timer0_output_a), .timer1_output_a(timer1_output_a),
	.timer2_output_a(timer2_output_a), .pad_in(pad_in), .pad_out_q(pad_out_q), .pad_oe_n_q(pad_oe_n_q),
	.timer0_clock_input_q(timer0_clock_input_q));
`default_nettype wire
